/* hw/oca_pkg.sv */
// Purpose: Shared constants and types for the option byte and code store access block
// Assumes: APB register bus with 32-bit data, one aligned word per register
// Notes:   Option byte field positions and delivered values live here only
`default_nettype none

package oca_pkg;

	// ********************************************************
	// Option byte layout and values
	// ********************************************************
	localparam int          POS_FACTORY = 7;
	localparam int          POS_POR     = 6;
	localparam int          POS_SEC     = 5;
	localparam int          POS_CLK_HI  = 4;
	localparam int          POS_CLK_LO  = 3;
	localparam int          POS_WDOG    = 2;
	localparam int          POS_RSVD    = 1;
	localparam int          POS_HALT    = 0;
	localparam logic [7:0]  ECON_WIN_RST = 8'h00;
	localparam logic [7:0]  ECON_OTP_RST = 8'h80;
	localparam logic [7:0]  SECURED_BYTE = 8'hFF;
	localparam logic [7:0]  ERASED_BYTE  = 8'h00;
	localparam int          USER_BYTES   = 8;

	// ********************************************************
	// Register map and fields
	// ********************************************************
	localparam int          APB_AW       = 12;
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_ADDR     = 12'h004;
	localparam logic [11:0] OFS_WDATA    = 12'h008;
	localparam logic [11:0] OFS_CMD      = 12'h00C;
	localparam logic [11:0] OFS_RDATA    = 12'h010;
	localparam logic [11:0] OFS_STATUS   = 12'h014;
	localparam int          POS_PMODE    = 0;
	localparam int          POS_REGION   = 16;
	localparam int          POS_CMD_WR   = 0;
	localparam int          POS_CMD_RD   = 1;
	localparam int          POS_CMD_ER   = 2;
	localparam int          POS_ST_PMODE = 0;
	localparam int          POS_ST_SEC   = 1;
	localparam int          POS_ST_REF   = 2;
	localparam int          POS_ST_BUSY  = 3;
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [1:0] {
		REG_CODE = 2'b00,
		REG_ECON = 2'b01,
		REG_USER = 2'b10
	} oca_region_type;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} oca_state_type;

	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} oca_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} oca_apb_rsp_type;

	typedef struct packed {
		logic       por_enable;
		logic       security;
		logic [1:0] clock_option;
		logic       watchdog_enable;
		logic       halt_disable;
	} oca_option_type;

endpackage : oca_pkg

`default_nettype wire

/* hw/oca_nvm.sv */
// Purpose: Flip-flop model of the code store, option byte and user bytes
// Assumes: Caller has already applied mode and security gating
// Notes:   Programming only sets bits; erase clears all but the security bit
`default_nettype none

module oca_nvm #(
	parameter int   CODE_BYTES = 4096,
	parameter int   AW         = 12,
	parameter logic WINDOWED   = 1'b0
) (
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire logic                   clk_en,
	input  wire logic                   wr_en,
	input  wire logic                   erase,
	input  wire oca_pkg::oca_region_type region,
	input  wire logic [AW-1:0]          addr,
	input  wire logic [7:0]             wr_data,
	input  wire logic [AW-1:0]          cpu_addr,
	output logic [7:0]                  ext_rdata,
	output logic [7:0]                  cpu_rdata,
	output logic [7:0]                  econ
);

	typedef struct packed {
		logic [CODE_BYTES-1:0][7:0]         code;
		logic [oca_pkg::USER_BYTES-1:0][7:0] user;
		logic [7:0]                         econ;
	} oca_nvm_type;

	oca_nvm_type cur;
	oca_nvm_type nxt;
	logic        code_ok;

	// ********************************************************
	// Next contents
	// ********************************************************
	// Programming ORs bits in, as a blank cell only moves away from zero
	always_comb begin
		nxt = cur;
		code_ok = 32'(addr) < CODE_BYTES;
		if (erase) begin
			nxt.code = '0;
			nxt.user = '0;
			nxt.econ = cur.econ & (8'h01 << oca_pkg::POS_SEC);
		end else if (wr_en) begin
			case (region)
				oca_pkg::REG_CODE: begin
					if (code_ok)
						nxt.code[addr] = cur.code[addr] | wr_data;
				end
				oca_pkg::REG_ECON: nxt.econ = cur.econ | wr_data;
				oca_pkg::REG_USER: nxt.user[addr[2:0]] = cur.user[addr[2:0]] | wr_data;
				default: nxt = cur;
			endcase
		end
	end

	// Reset stands for the delivered state of the part
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cur.code <= '0;
			cur.user <= '0;
			cur.econ <= WINDOWED ? oca_pkg::ECON_WIN_RST : oca_pkg::ECON_OTP_RST;
		end else if (clk_en) begin
			cur <= nxt;
		end
	end

	// ********************************************************
	// Read ports
	// ********************************************************
	always_comb begin
		case (region)
			oca_pkg::REG_CODE: ext_rdata = code_ok ? cur.code[addr] : oca_pkg::ERASED_BYTE;
			oca_pkg::REG_ECON: ext_rdata = cur.econ;
			oca_pkg::REG_USER: ext_rdata = cur.user[addr[2:0]];
			default:           ext_rdata = oca_pkg::ERASED_BYTE;
		endcase
	end

	// Fetch port sees the code area only
	assign cpu_rdata = (32'(cpu_addr) < CODE_BYTES) ? cur.code[cpu_addr] : oca_pkg::ERASED_BYTE;
	assign econ      = cur.econ;

endmodule : oca_nvm

`default_nettype wire

/* hw/oca_access.sv */
// Purpose: Programming-mode access and protection for the code store and option byte
// Assumes: APB master on sys_clk; reset_n synchronous, active low
// Notes:   One command runs in the cycle after its CMD write
//
// Function
// - Option byte is written and read only while programming mode is on.
// - Delivered option byte reads 00 on windowed parts, 80 on one-time parts.
// - Option byte selects clock source, security, reset, watchdog and halt.
// - Secured part returns FF for every external code read.
// - Secured part ignores writes to code and option byte.
// - Option byte stays readable whether secured or not.
// - Security bit survives erase; secured part refuses further code programming.
// - Eight user bytes are readable and writable in programming mode, secured or not.
// - Option and user bytes are unreachable from the instruction fetch port.
// - Unsecured part returns true stored code on external reads.
// - Erased code locations read 00.
`default_nettype none

module oca_access #(
	parameter int   CODE_BYTES = 4096,
	parameter int   AW         = $clog2(CODE_BYTES),
	parameter logic WINDOWED   = 1'b0
) (
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire logic                     clk_en,
	input  wire oca_pkg::oca_apb_req_type apb_req,
	output oca_pkg::oca_apb_rsp_type      apb_rsp,
	input  wire logic [AW-1:0]            cpu_addr,
	output logic [7:0]                    cpu_rdata,
	output oca_pkg::oca_option_type       options
);

	typedef struct packed {
		logic                    pmode;
		logic [AW-1:0]           addr;
		oca_pkg::oca_region_type region;
		logic [7:0]              wdata;
		logic [7:0]              rdata;
		logic                    refused;
		oca_pkg::oca_state_type  state;
		logic [2:0]              cmd;
		logic [7:0]              cpu_data;
		logic [31:0]             prdata;
	} oca_ctl_type;

	oca_ctl_type cur;
	oca_ctl_type nxt;

	logic        setup;
	logic        access;
	logic        mapped;
	logic        secured;
	logic        exec;
	logic        do_erase;
	logic        do_write;
	logic        do_read;
	logic        ref_clr;
	logic [31:0] rd_word;
	logic [7:0]  nvm_ext_rdata;
	logic [7:0]  nvm_cpu_rdata;
	logic [7:0]  nvm_econ;

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ********************************************************
	// Storage
	// ********************************************************
	oca_nvm #(
		.CODE_BYTES (CODE_BYTES),
		.AW         (AW),
		.WINDOWED   (WINDOWED)
	) u_nvm (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.wr_en     (do_write),
		.erase     (do_erase),
		.region    (cur.region),
		.addr      (cur.addr),
		.wr_data   (cur.wdata),
		.cpu_addr  (cpu_addr),
		.ext_rdata (nvm_ext_rdata),
		.cpu_rdata (nvm_cpu_rdata),
		.econ      (nvm_econ)
	);

	// ********************************************************
	// Command gating
	// ********************************************************
	// Every external operation needs programming mode; the user area ignores security
	always_comb begin
		secured  = nvm_econ[oca_pkg::POS_SEC];
		exec     = (cur.state == oca_pkg::ST_EXEC);
		do_erase = exec && cur.pmode && WINDOWED && cur.cmd[oca_pkg::POS_CMD_ER];
		do_write = exec && cur.pmode && !cur.cmd[oca_pkg::POS_CMD_ER]
			&& cur.cmd[oca_pkg::POS_CMD_WR]
			&& ((cur.region == oca_pkg::REG_USER)
			|| (!secured && (cur.region != 2'b11)));
		do_read  = exec && cur.pmode && !cur.cmd[oca_pkg::POS_CMD_ER]
			&& !cur.cmd[oca_pkg::POS_CMD_WR] && cur.cmd[oca_pkg::POS_CMD_RD];
	end

	// ********************************************************
	// Bus phases and decode
	// ********************************************************
	assign setup  = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign mapped = hit(apb_req.paddr, oca_pkg::OFS_CTRL) || hit(apb_req.paddr, oca_pkg::OFS_ADDR)
		|| hit(apb_req.paddr, oca_pkg::OFS_WDATA) || hit(apb_req.paddr, oca_pkg::OFS_CMD)
		|| hit(apb_req.paddr, oca_pkg::OFS_RDATA) || hit(apb_req.paddr, oca_pkg::OFS_STATUS);
	assign ref_clr = access && apb_req.pwrite && hit(apb_req.paddr, oca_pkg::OFS_STATUS)
		&& apb_req.pwdata[oca_pkg::POS_ST_REF];

	// Read word is chosen at setup, so the access phase can answer at once
	always_comb begin
		rd_word = oca_pkg::RST_WORD;
		if (hit(apb_req.paddr, oca_pkg::OFS_CTRL)) begin
			rd_word[oca_pkg::POS_PMODE] = cur.pmode;
		end else if (hit(apb_req.paddr, oca_pkg::OFS_ADDR)) begin
			rd_word[AW-1:0] = cur.addr;
			rd_word[oca_pkg::POS_REGION +: 2] = cur.region;
		end else if (hit(apb_req.paddr, oca_pkg::OFS_WDATA)) begin
			rd_word[7:0] = cur.wdata;
		end else if (hit(apb_req.paddr, oca_pkg::OFS_CMD)) begin
			rd_word[2:0] = cur.cmd;
		end else if (hit(apb_req.paddr, oca_pkg::OFS_RDATA)) begin
			rd_word[7:0] = cur.rdata;
		end else if (hit(apb_req.paddr, oca_pkg::OFS_STATUS)) begin
			rd_word[oca_pkg::POS_ST_PMODE] = cur.pmode;
			rd_word[oca_pkg::POS_ST_SEC]   = secured;
			rd_word[oca_pkg::POS_ST_REF]   = cur.refused;
			rd_word[oca_pkg::POS_ST_BUSY]  = exec;
		end
	end

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb begin
		nxt = cur;
		if (setup && !apb_req.pwrite)
			nxt.prdata = rd_word;
		// Register writes land at the access edge
		if (access && apb_req.pwrite) begin
			if (hit(apb_req.paddr, oca_pkg::OFS_CTRL)) begin
				nxt.pmode = apb_req.pwdata[oca_pkg::POS_PMODE];
			end else if (hit(apb_req.paddr, oca_pkg::OFS_ADDR)) begin
				nxt.addr   = apb_req.pwdata[AW-1:0];
				nxt.region = oca_pkg::oca_region_type'(apb_req.pwdata[oca_pkg::POS_REGION +: 2]);
			end else if (hit(apb_req.paddr, oca_pkg::OFS_WDATA)) begin
				nxt.wdata = apb_req.pwdata[7:0];
			end else if (hit(apb_req.paddr, oca_pkg::OFS_CMD)) begin
				if (!exec && (apb_req.pwdata[2:0] != 3'h0)) begin
					nxt.cmd   = apb_req.pwdata[2:0];
					nxt.state = oca_pkg::ST_EXEC;
				end
			end
		end
		// Sticky refusal flag; a new refusal beats the clear
		if (ref_clr)
			nxt.refused = 1'b0;
		case (cur.state)
			oca_pkg::ST_IDLE: begin
			end
			oca_pkg::ST_EXEC: begin
				if (do_read) begin
					if ((cur.region == oca_pkg::REG_CODE) && secured)
						nxt.rdata = oca_pkg::SECURED_BYTE;
					else
						nxt.rdata = nvm_ext_rdata;
				end
				if (!(do_read || do_write || do_erase))
					nxt.refused = 1'b1;
				nxt.state = oca_pkg::ST_IDLE;
			end
			default: nxt.state = oca_pkg::ST_IDLE;
		endcase
		// Fetch data is registered so the fetch port never sees a glitch
		nxt.cpu_data = nvm_cpu_rdata;
	end

	// ********************************************************
	// State register
	// ********************************************************
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cur.pmode    <= 1'b0;
			cur.addr     <= '0;
			cur.region   <= oca_pkg::REG_CODE;
			cur.wdata    <= oca_pkg::ERASED_BYTE;
			cur.rdata    <= oca_pkg::ERASED_BYTE;
			cur.refused  <= 1'b0;
			cur.state    <= oca_pkg::ST_IDLE;
			cur.cmd      <= 3'h0;
			cur.cpu_data <= oca_pkg::ERASED_BYTE;
			cur.prdata   <= oca_pkg::RST_WORD;
		end else if (clk_en) begin
			cur <= nxt;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	// Zero wait states; stalling on clk_en low is the master's to avoid
	assign apb_rsp = '{
		prdata:  cur.prdata,
		pready:  1'b1,
		pslverr: access && !mapped
	};
	assign cpu_rdata = cur.cpu_data;

	// Option fields straight from the stored byte
	always_comb begin
		options.por_enable      = nvm_econ[oca_pkg::POS_POR];
		options.security        = nvm_econ[oca_pkg::POS_SEC];
		options.clock_option    = {nvm_econ[oca_pkg::POS_CLK_HI], nvm_econ[oca_pkg::POS_CLK_LO]};
		options.watchdog_enable = nvm_econ[oca_pkg::POS_WDOG];
		options.halt_disable    = nvm_econ[oca_pkg::POS_HALT];
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_exec;
		exec && clk_en;
	endsequence

	sequence s_rd(oca_pkg::oca_region_type r);
		s_exec ##0 (cur.cmd == 3'h2) && (cur.region == r);
	endsequence

	sequence s_wr(oca_pkg::oca_region_type r);
		s_exec ##0 (cur.cmd == 3'h1) && (cur.region == r);
	endsequence

	chk_econ_pmode_only: assert property (
		s_wr(oca_pkg::REG_ECON) ##0 !cur.pmode |=> $stable(nvm_econ) && cur.refused)
		else $error("option byte changed outside programming mode");

	chk_delivered_econ: assert property (
		$past(!reset_n) |-> (nvm_econ == (WINDOWED ? oca_pkg::ECON_WIN_RST : oca_pkg::ECON_OTP_RST)))
		else $error("delivered option byte wrong");

	chk_secured_read_ff: assert property (
		s_rd(oca_pkg::REG_CODE) ##0 cur.pmode && secured |=> cur.rdata == oca_pkg::SECURED_BYTE)
		else $error("secured code read leaked data");

	chk_secured_no_write: assert property (
		s_wr(oca_pkg::REG_ECON) ##0 secured |=> $stable(nvm_econ) ##1 $stable(nvm_econ))
		else $error("secured option byte was written");

	chk_econ_read_any: assert property (
		s_rd(oca_pkg::REG_ECON) ##0 cur.pmode |=> cur.rdata == $past(nvm_econ))
		else $error("option byte read wrong");

	chk_sec_sticky: assert property (
		nvm_econ[oca_pkg::POS_SEC] |=> nvm_econ[oca_pkg::POS_SEC] [*2])
		else $error("security bit cleared");

	chk_user_open: assert property (
		s_wr(oca_pkg::REG_USER) ##0 cur.pmode
		|=> nvm_ext_rdata == ($past(nvm_ext_rdata) | $past(cur.wdata)))
		else $error("user byte write lost");

	chk_fetch_follow: assert property (
		clk_en |=> cpu_rdata == $past(nvm_cpu_rdata))
		else $error("fetch data mismatch");

	chk_open_read: assert property (
		s_rd(oca_pkg::REG_CODE) ##0 cur.pmode && !secured |=> cur.rdata == $past(nvm_ext_rdata))
		else $error("unsecured code read wrong");

	chk_erase_blank: assert property (
		s_exec ##0 do_erase && (cur.region == oca_pkg::REG_CODE)
		|=> nvm_ext_rdata == oca_pkg::ERASED_BYTE)
		else $error("erased code not blank");

	// ********************************************************
	// Refusal and open-area checks
	// ********************************************************
	// Programming-mode command against a secured store
	sequence s_sec_wr(oca_pkg::oca_region_type r);
		s_wr(r) ##0 cur.pmode && secured;
	endsequence

	// A command with programming mode off must be refused and leave the option byte and RDATA as they were
	chk_nomode_refused: assert property (
		s_exec ##0 !cur.pmode |=> cur.refused)
		else $error("command outside programming mode not refused");

	chk_nomode_nochange: assert property (
		s_exec ##0 !cur.pmode |=> $stable(nvm_econ) && $stable(cur.rdata))
		else $error("command outside programming mode took effect");

	// Programming only ever sets bits, so a write ORs into the byte
	chk_econ_write_open: assert property (
		s_wr(oca_pkg::REG_ECON) ##0 cur.pmode && !secured
		|=> nvm_econ == ($past(nvm_econ) | $past(cur.wdata)))
		else $error("option byte write lost in programming mode");

	chk_econ_write_refused: assert property (
		s_sec_wr(oca_pkg::REG_ECON) |=> cur.refused)
		else $error("secured option byte write not refused");

	chk_code_write_refused: assert property (
		s_sec_wr(oca_pkg::REG_CODE) |=> cur.refused)
		else $error("secured code write not refused");

	chk_code_write_blocked: assert property (
		s_sec_wr(oca_pkg::REG_CODE) |=> $stable(nvm_ext_rdata))
		else $error("secured code byte changed");

	chk_econ_read_secured: assert property (
		s_rd(oca_pkg::REG_ECON) ##0 cur.pmode && secured |=> cur.rdata == $past(nvm_econ))
		else $error("secured option byte read wrong");

	// Erase wipes the array but must never reopen a secured part
	chk_erase_keeps_sec: assert property (
		s_exec ##0 do_erase |=> secured == $past(secured))
		else $error("erase changed the security bit");

	// User bytes answer in programming mode whatever the security bit says
	chk_user_read_open: assert property (
		s_rd(oca_pkg::REG_USER) ##0 cur.pmode |=> cur.rdata == $past(nvm_ext_rdata))
		else $error("user byte read wrong");

	chk_user_write_open: assert property (
		s_wr(oca_pkg::REG_USER) ##0 cur.pmode |=> !$rose(cur.refused))
		else $error("user byte write refused");

endmodule : oca_access

`default_nettype wire

/* verification/oca_prog_model.sv */
// Purpose: Programmer-side model that drives the APB port of the access block
// Assumes: Tasks are entered just after a rising edge of sys_clk
// Notes:   Released address and data lines carry inverted values, not stale ones
`default_nettype none

module oca_prog_model (
	input  wire logic                     sys_clk,
	output oca_pkg::oca_apb_req_type      req,
	input  wire oca_pkg::oca_apb_rsp_type rsp,
	output logic                          rd_stb,
	output logic [32:0]                   rd_val,
	output logic                          hang
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********************
	// Bus master
	// ********************

	// Idle bus at time zero
	initial begin
		req = '0;
		rd_stb = 1'b0;
		rd_val = '0;
		hang = 1'b0;
	end

	// Read strobe lasts one cycle so each result is seen once
	always @(posedge sys_clk) begin
		if (rd_stb) begin
			rd_stb <= 1'b0;
		end
	end

	// One transfer; request held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req.paddr <= a;
		req.pwrite <= w;
		req.pwdata <= d;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		if (rsp.pready !== 1'b1) begin
			hang <= 1'b1;
		end else if (!w) begin
			rd_stb <= 1'b1;
			rd_val <= {rsp.pslverr, rsp.prdata};
		end
		// Released lines must not look like valid data
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		req.paddr <= ~a;
		req.pwdata <= ~d;
		// Idle edge keeps the release apart from the next setup
		@(posedge sys_clk);
	endtask : xfer

endmodule : oca_prog_model

`default_nettype wire

/* verification/tb.sv */
// Purpose: Self-checking bench for the option byte and code store access block
// Assumes: One-time part and windowed part share one programmer bus
// Notes:   Reads are scored against a queue of notes; port values compared directly
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************
	// Signals and instances
	// ********************
	localparam int         CB   = 64;
	localparam logic [2:0] C_WR = 3'(1 << oca_pkg::POS_CMD_WR);
	localparam logic [2:0] C_RD = 3'(1 << oca_pkg::POS_CMD_RD);
	localparam logic [2:0] C_ER = 3'(1 << oca_pkg::POS_CMD_ER);

	logic                     sys_clk;
	logic                     reset_n;
	logic                     use_win;
	logic [5:0]               cpu_addr;
	logic [7:0]               cpu_rdata;
	logic                     rd_stb;
	logic                     hang;
	logic [32:0]              rd_val;
	oca_pkg::oca_apb_req_type apb_req;
	oca_pkg::oca_apb_rsp_type rsp_u;
	oca_pkg::oca_apb_rsp_type rsp_w;
	oca_pkg::oca_option_type  options;
	logic [32:0]              exp_q[$];
	logic [7:0]               mem[4];
	int                       failures;
	int                       checks;

	oca_access #(.CODE_BYTES(CB), .WINDOWED(1'b0)) dut_u (.sys_clk(sys_clk),
		.reset_n(reset_n), .clk_en(1'b1), .apb_req(apb_req), .apb_rsp(rsp_u),
		.cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .options(options));
	oca_access #(.CODE_BYTES(CB), .WINDOWED(1'b1)) dut_w (.sys_clk(sys_clk),
		.reset_n(reset_n), .clk_en(1'b1), .apb_req(apb_req), .apb_rsp(rsp_w),
		.cpu_addr(cpu_addr), .cpu_rdata(), .options());
	oca_prog_model prog_u (.sys_clk(sys_clk), .req(apb_req), .rsp(use_win ? rsp_w : rsp_u),
		.rd_stb(rd_stb), .rd_val(rd_val), .hang(hang));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// ********************
	// Tasks
	// ********************
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic mism(input string m);
		failures++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : mism

	task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
		checks++;
		if (g !== e) mism($sformatf("read got %h want %h", g, e));
	endtask : chk_rd

	task automatic chk_v(input logic [31:0] g, input logic [31:0] e, input string w);
		checks++;
		if (g !== e) mism($sformatf("%s got %h want %h", w, g, e));
	endtask : chk_v

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		prog_u.xfer(1'b1, a, d);
	endtask : wr

	// Note the expectation first, then run the read
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
		exp_q.push_back({err, e});
		prog_u.xfer(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Spare edge lets the command land before RDATA is captured
	task automatic op(input logic [1:0] rg, input logic [7:0] ad, input logic [2:0] c,
		input logic [7:0] d);
		wr(oca_pkg::OFS_ADDR, {14'h0000, rg, 8'h00, ad});
		wr(oca_pkg::OFS_WDATA, {24'h00_0000, d});
		wr(oca_pkg::OFS_CMD, {29'h0000_0000, c});
		@(posedge sys_clk);
	endtask : op

	function automatic logic [31:0] opt_of(input logic [7:0] b);
		return {26'h000_0000, b[6], b[5], b[4], b[3], b[2], b[0]};
	endfunction : opt_of

	// Scoreboard: oldest note against each completed read; also hang watch
	always @(posedge sys_clk) begin
		if (rd_stb) begin
			if (exp_q.size() == 0) mism("read with no note");
			else chk_rd(exp_q.pop_front(), rd_val);
		end
		if (hang) begin
			mism("pready wait ran out");
			end_sim();
		end
	end

	// ********************
	// Main sequence
	// ********************
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		use_win = 1'b0;
		cpu_addr = '0;
		failures = 0;
		checks = 0;
		void'($urandom(61268));
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk_v(32'(options), 32'h0000_0000, "options");
		rd(oca_pkg::OFS_STATUS, 32'h0000_0000);
		rd(12'h018, 32'h0000_0000, 1'b1);
		$display("test reset done");
		// Commands outside programming mode are refused and change nothing
		op(2'd1, 8'h00, C_RD, 8'h00);
		rd(oca_pkg::OFS_STATUS, 32'h0000_0004);
		wr(oca_pkg::OFS_STATUS, 32'h0000_0004);
		op(2'd1, 8'h00, C_WR, 8'h01);
		rd(oca_pkg::OFS_STATUS, 32'h0000_0004);
		wr(oca_pkg::OFS_STATUS, 32'h0000_0004);
		wr(oca_pkg::OFS_CTRL, 32'h0000_0001);
		op(2'd1, 8'h00, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_0080);
		use_win <= 1'b1;
		rd(oca_pkg::OFS_RDATA, 32'h0000_0000);
		use_win <= 1'b0;
		$display("test mode gate done");
		// Random code bytes, read back and fetched
		for (int i = 0; i < 4; i++) begin
			mem[i] = 8'($urandom);
			op(2'd0, 8'(i), C_WR, mem[i]);
			op(2'd0, 8'(i), C_RD, 8'h00);
			rd(oca_pkg::OFS_RDATA, {24'h00_0000, mem[i]});
			cpu_addr <= 6'(i);
			repeat (2) @(posedge sys_clk);
			chk_v(32'(cpu_rdata), 32'(mem[i]), "fetch");
		end
		op(2'd0, 8'h05, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_0000);
		$display("test code done");
		op(2'd1, 8'h00, C_WR, 8'h55);
		@(posedge sys_clk);
		chk_v(32'(options), opt_of(8'hD5), "options");
		op(2'd1, 8'h00, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_00D5);
		op(2'd2, 8'h03, C_WR, 8'hA5);
		op(2'd2, 8'h03, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_00A5);
		$display("test options done");
		// Security bit set last, after option bits 6, 4, 2 and 0
		op(2'd1, 8'h00, C_WR, 8'h20);
		@(posedge sys_clk);
		chk_v(32'(options), opt_of(8'hF5), "options");
		rd(oca_pkg::OFS_STATUS, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			op(2'd0, 8'(i), C_RD, 8'h00);
			rd(oca_pkg::OFS_RDATA, 32'h0000_00FF);
		end
		op(2'd1, 8'h00, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_00F5);
		op(2'd0, 8'h00, C_WR, 8'hFF);
		rd(oca_pkg::OFS_STATUS, 32'h0000_0007);
		wr(oca_pkg::OFS_STATUS, 32'h0000_0004);
		op(2'd1, 8'h00, C_WR, 8'h02);
		op(2'd1, 8'h00, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_00F5);
		wr(oca_pkg::OFS_STATUS, 32'h0000_0004);
		op(2'd2, 8'h04, C_WR, 8'h3C);
		op(2'd2, 8'h04, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_003C);
		rd(oca_pkg::OFS_STATUS, 32'h0000_0003);
		$display("test security done");
		// Windowed part: erase keeps security and blocks code programming
		use_win <= 1'b1;
		op(2'd0, 8'h00, C_ER, 8'h00);
		rd(oca_pkg::OFS_STATUS, 32'h0000_0003);
		op(2'd1, 8'h00, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_0020);
		op(2'd2, 8'h03, C_RD, 8'h00);
		rd(oca_pkg::OFS_RDATA, 32'h0000_0000);
		op(2'd0, 8'h01, C_WR, 8'h11);
		rd(oca_pkg::OFS_STATUS, 32'h0000_0007);
		$display("test erase done");
		repeat (3) @(posedge sys_clk);
		if (exp_q.size() != 0) mism("notes left unread");
		end_sim();
	end

endmodule : tb

`default_nettype wire
